// ### design/jtag_dbg_cfg.svh
`ifndef JTAG_DBG_CFG_SVH
`define JTAG_DBG_CFG_SVH
// ----------------------------------------
// debug register addresses
// ----------------------------------------
`define RA_DBG_CTRL  5'h00
`define RA_DBG_STAT  5'h01
`define RA_COMM_CTRL 5'h04
`define RA_COMM_DATA 5'h05
`define RA_UNIT0     2'h1
`define RA_UNIT1     2'h2
`define WF_ADDR_VAL  3'h0
`define WF_ADDR_MASK 3'h1
`define WF_DATA_VAL  3'h2
`define WF_DATA_MASK 3'h3
`define WF_CTRL_VAL  3'h4
`define WF_CTRL_MASK 3'h5
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define DC_FORCE     0
`define DC_INTDIS    1
`define DC_CHAIN     2
`define DC_RANGE     3
`define DC_RELEASE   5
`define DC_RESET     6'h00
`define WC_ENABLE    8
`define WC_FETCH     0
`define CC_RX_FULL   0
`define CC_TX_FULL   1
// ----------------------------------------
// test port codes and chain lengths
// ----------------------------------------
`define IR_SCAN_N    4'h2
`define IR_INTEST    4'hc
`define IR_BYPASS    4'hf
`define IR_CAPTURE   4'h1
`define CHAIN_CORE   4'h1
`define CHAIN_DEBUG  4'h2
`define CP_DEBUG     4'he
`define LEN_DEBUG    38
`define LEN_CORE     33
`define LEN_SEL      4
`define LEN_BYPASS   1
`endif

// ### design/jtag_dbg_pkg.sv
package jtag_dbg_pkg;
  typedef enum logic [3:0] {
    st_reset = 4'h0, st_idle  = 4'h1, st_sdr   = 4'h2, st_cdr   = 4'h3,
    st_shdr  = 4'h4, st_e1dr  = 4'h5, st_pdr   = 4'h6, st_e2dr  = 4'h7,
    st_udr   = 4'h8, st_sir   = 4'h9, st_cir   = 4'ha, st_shir  = 4'hb,
    st_e1ir  = 4'hc, st_pir   = 4'hd, st_e2ir  = 4'he, st_uir   = 4'hf
  } tap_state_t;

  typedef struct packed {
    tap_state_t  state;
    logic [3:0]  ir;
    logic [3:0]  chain;
    logic [37:0] shift;
    logic        req_tgl;
    logic        req_core;
    logic        req_write;
    logic [4:0]  req_addr;
    logic [31:0] req_data;
    logic        req_fast;
    logic        ack_s1, ack_s2, ack_seen;
    logic [31:0] rd_hold;
  } tck_state_t;

  typedef struct packed {
    logic [1:0][31:0] av, am, dv, dm;
    logic [1:0][8:0]  cv;
    logic [1:0][7:0]  cm;
    logic [5:0]       dctrl;
    logic             halted, armed;
    logic [1:0]       hit;
    logic [31:0]      rx_data, tx_data;
    logic             rx_full, tx_full;
    logic [31:0]      rd_word;
    logic             ack_tgl, req_s1, req_s2, req_seen;
    logic             tck_s1, tck_s2, returned_test_clock;
    logic [31:0]      cp_rdata;
    logic             cp_ack;
    logic [31:0]      ins_data;
    logic             ins_valid, ins_fast;
  } sys_state_t;
endpackage

// ### design/jtag_watchpoint_debug_unit.sv
`timescale 1ns/1ps
`include "jtag_dbg_cfg.svh"
`default_nettype none
module jtag_watchpoint_debug_unit
  import jtag_dbg_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        TCK,
  input  wire logic        TMS,
  input  wire logic        TDI,
  input  wire logic        TRST_N,
  output var  logic        TDO,
  output var  logic        TDO_OE,
  output var  logic        RETURNED_TEST_CLOCK,
  input  wire logic        CORE_ACCESS,
  input  wire logic        CORE_FETCH,
  input  wire logic [31:0] CORE_ADDR,
  input  wire logic [31:0] CORE_DATA,
  input  wire logic [6:0]  CORE_CTRL,
  output var  logic        CORE_HALT,
  output var  logic        CORE_INT_DISABLE,
  output var  logic        INSERT_VALID,
  output var  logic [31:0] INSERT_DATA,
  output var  logic        INSERT_FAST,
  input  wire logic        CP_REQ,
  input  wire logic [3:0]  CP_NUM,
  input  wire logic        CP_WRITE,
  input  wire logic        CP_SEL,
  input  wire logic [31:0] CP_WDATA,
  output var  logic        CP_ACK,
  output var  logic [31:0] CP_RDATA
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic masked_eq(input logic [31:0] v, m, x);
    return ((v ^ x) & ~m) == 32'h0;
  endfunction

  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    case (s)
      st_reset: tap_next = m ? st_reset : st_idle;
      st_idle:  tap_next = m ? st_sdr : st_idle;
      st_sdr:   tap_next = m ? st_sir : st_cdr;
      st_cdr:   tap_next = m ? st_e1dr : st_shdr;
      st_shdr:  tap_next = m ? st_e1dr : st_shdr;
      st_e1dr:  tap_next = m ? st_udr : st_pdr;
      st_pdr:   tap_next = m ? st_e2dr : st_pdr;
      st_e2dr:  tap_next = m ? st_udr : st_shdr;
      st_udr:   tap_next = m ? st_sdr : st_idle;
      st_sir:   tap_next = m ? st_reset : st_cir;
      st_cir:   tap_next = m ? st_e1ir : st_shir;
      st_shir:  tap_next = m ? st_e1ir : st_shir;
      st_e1ir:  tap_next = m ? st_uir : st_pir;
      st_pir:   tap_next = m ? st_e2ir : st_pir;
      st_e2ir:  tap_next = m ? st_uir : st_shir;
      st_uir:   tap_next = m ? st_sdr : st_idle;
      default:  tap_next = st_reset;
    endcase
  endfunction

  function automatic int dr_len(input logic [3:0] ir, chain);
    if (ir == `IR_SCAN_N) return `LEN_SEL;
    if (ir == `IR_INTEST && chain == `CHAIN_DEBUG) return `LEN_DEBUG;
    if (ir == `IR_INTEST && chain == `CHAIN_CORE) return `LEN_CORE;
    return `LEN_BYPASS;
  endfunction

  function automatic logic [37:0] shift_in(input logic [37:0] v, input logic b,
                                           input int len);
    logic [37:0] r;
    r = v >> 1;
    r[len-1] = b;
    return r;
  endfunction

  function automatic logic [31:0] rd_reg(input sys_state_t s, input logic [4:0] a);
    logic u;
    u = a[4];
    rd_reg = 32'h0;
    case (a)
      `RA_DBG_CTRL:  rd_reg = {26'h0, s.dctrl};
      `RA_DBG_STAT:  rd_reg = {27'h0, s.hit, s.armed, s.dctrl[`DC_INTDIS], s.halted};
      `RA_COMM_CTRL: rd_reg = {30'h0, s.tx_full, s.rx_full};
      `RA_COMM_DATA: rd_reg = s.tx_data;
      default: begin
        if (a[4:3] == `RA_UNIT0 || a[4:3] == `RA_UNIT1) begin
          case (a[2:0])
            `WF_ADDR_VAL:  rd_reg = s.av[u];
            `WF_ADDR_MASK: rd_reg = s.am[u];
            `WF_DATA_VAL:  rd_reg = s.dv[u];
            `WF_DATA_MASK: rd_reg = s.dm[u];
            `WF_CTRL_VAL:  rd_reg = {23'h0, s.cv[u]};
            `WF_CTRL_MASK: rd_reg = {24'h0, s.cm[u]};
            default:       rd_reg = 32'h0;
          endcase
        end
      end
    endcase
  endfunction

  tck_state_t t, next_t;
  sys_state_t s, next_s;
  logic [1:0] hit;
  logic       trig, release_req;
  logic       rx_set, rx_clr, tx_set, tx_clr;

  // ----------------------------------------
  // test clock domain
  // ----------------------------------------
  always_comb begin
    next_t = t;
    next_t.state = tap_next(t.state, TMS);
    // acknowledge toggle crosses back; read word is only taken on its edge
    next_t.ack_s1 = s.ack_tgl;
    next_t.ack_s2 = t.ack_s1;
    if (t.ack_s2 != t.ack_seen) begin
      next_t.ack_seen = t.ack_s2;
      next_t.rd_hold = s.rd_word;
    end
    case (t.state)
      st_reset: begin
        next_t.ir = `IR_BYPASS;
      end
      st_cir: begin
        next_t.shift = {34'h0, `IR_CAPTURE};
      end
      st_shir: begin
        next_t.shift = shift_in(t.shift, TDI, `LEN_SEL);
      end
      st_uir: begin
        next_t.ir = t.shift[3:0];
      end
      st_cdr: begin
        if (t.ir == `IR_SCAN_N) begin
          next_t.shift = {34'h0, t.chain};
        end else if (t.ir == `IR_INTEST) begin
          next_t.shift = {6'h0, t.rd_hold};
        end else begin
          next_t.shift = 38'h0;
        end
      end
      st_shdr: begin
        next_t.shift = shift_in(t.shift, TDI, dr_len(t.ir, t.chain));
      end
      st_udr: begin
        if (t.ir == `IR_SCAN_N) begin
          next_t.chain = t.shift[3:0];
        end else if (t.ir == `IR_INTEST && t.chain == `CHAIN_DEBUG) begin
          next_t.req_core = 1'b0;
          next_t.req_write = t.shift[37];
          next_t.req_addr = t.shift[36:32];
          next_t.req_data = t.shift[31:0];
          next_t.req_tgl = ~t.req_tgl;
        end else if (t.ir == `IR_INTEST && t.chain == `CHAIN_CORE) begin
          next_t.req_core = 1'b1;
          next_t.req_write = 1'b1;
          next_t.req_data = t.shift[31:0];
          next_t.req_fast = t.shift[32];
          next_t.req_tgl = ~t.req_tgl;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      t <= '{state: st_reset, ir: `IR_BYPASS, default: '0};
    end else begin
      t <= next_t;
    end
  end

  // data out moves half a clock ahead of the debugger's sampling edge
  always_ff @(negedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
    end else begin
      TDO <= t.shift[0];
      TDO_OE <= (t.state == st_shdr) || (t.state == st_shir);
    end
  end

  // ----------------------------------------
  // system clock domain
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.ins_valid = 1'b0;
    next_s.cp_ack = 1'b0;
    release_req = 1'b0;
    rx_set = 1'b0;
    rx_clr = 1'b0;
    tx_set = 1'b0;
    tx_clr = 1'b0;
    next_s.tck_s1 = TCK;
    next_s.tck_s2 = s.tck_s1;
    next_s.returned_test_clock = s.tck_s2;
    next_s.req_s1 = t.req_tgl;
    next_s.req_s2 = s.req_s1;
    for (int i = 0; i < 2; i++) begin
      hit[i] = CORE_ACCESS && s.cv[i][`WC_ENABLE]
             && masked_eq(s.av[i], s.am[i], CORE_ADDR)
             && masked_eq(s.dv[i], s.dm[i], CORE_DATA)
             && masked_eq({24'h0, s.cv[i][7:0]}, {24'hffffff, s.cm[i]},
                          {24'h0, CORE_CTRL, CORE_FETCH});
    end
    if (s.dctrl[`DC_CHAIN]) begin
      trig = hit[1] && s.armed;
    end else if (s.dctrl[`DC_RANGE]) begin
      trig = hit[0] && !hit[1];
    end else begin
      trig = hit[0] || hit[1];
    end
    // request word is stable while the toggle is unanswered
    if (s.req_s2 != s.req_seen) begin
      next_s.req_seen = s.req_s2;
      next_s.ack_tgl = ~s.ack_tgl;
      if (t.req_core) begin
        next_s.rd_word = CORE_DATA;
        if (s.halted) begin
          next_s.ins_valid = 1'b1;
          next_s.ins_data = t.req_data;
          next_s.ins_fast = t.req_fast;
        end
      end else if (t.req_write) begin
        case (t.req_addr)
          `RA_DBG_CTRL: begin
            next_s.dctrl = t.req_data[5:0] & 6'h1f;
            release_req = t.req_data[`DC_RELEASE];
          end
          `RA_COMM_DATA: begin
            next_s.rx_data = t.req_data;
            rx_set = 1'b1;
          end
          default: begin
            if (t.req_addr[4:3] == `RA_UNIT0 || t.req_addr[4:3] == `RA_UNIT1) begin
              case (t.req_addr[2:0])
                `WF_ADDR_VAL:  next_s.av[t.req_addr[4]] = t.req_data;
                `WF_ADDR_MASK: next_s.am[t.req_addr[4]] = t.req_data;
                `WF_DATA_VAL:  next_s.dv[t.req_addr[4]] = t.req_data;
                `WF_DATA_MASK: next_s.dm[t.req_addr[4]] = t.req_data;
                `WF_CTRL_VAL:  next_s.cv[t.req_addr[4]] = t.req_data[8:0];
                `WF_CTRL_MASK: next_s.cm[t.req_addr[4]] = t.req_data[7:0];
                default: begin
                end
              endcase
            end
          end
        endcase
      end else begin
        next_s.rd_word = rd_reg(s, t.req_addr);
        tx_clr = (t.req_addr == `RA_COMM_DATA);
      end
    end
    // coprocessor port; runs whether or not the core is halted
    if (CP_REQ && CP_NUM == `CP_DEBUG) begin
      next_s.cp_ack = 1'b1;
      if (CP_WRITE) begin
        if (CP_SEL) begin
          next_s.tx_data = CP_WDATA;
          tx_set = 1'b1;
        end
      end else if (CP_SEL) begin
        next_s.cp_rdata = s.rx_data;
        rx_clr = 1'b1;
      end else begin
        next_s.cp_rdata = {30'h0, s.tx_full, s.rx_full};
      end
    end
    // a new word wins over a consume in the same cycle
    next_s.rx_full = rx_set || (s.rx_full && !rx_clr);
    next_s.tx_full = tx_set || (s.tx_full && !tx_clr);
    next_s.armed = s.dctrl[`DC_CHAIN] && (hit[0] || (s.armed && !release_req));
    next_s.hit = hit | (s.hit & {2{!release_req}});
    next_s.halted = trig || s.dctrl[`DC_FORCE] || (s.halted && !release_req);
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s <= '{dctrl: `DC_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign RETURNED_TEST_CLOCK = s.returned_test_clock;
  assign CORE_HALT = s.halted;
  assign CORE_INT_DISABLE = s.dctrl[`DC_INTDIS];
  assign INSERT_VALID = s.ins_valid;
  assign INSERT_DATA = s.ins_data;
  assign INSERT_FAST = s.ins_fast;
  assign CP_ACK = s.cp_ack;
  assign CP_RDATA = s.cp_rdata;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_tms_reset: assert property (
    @(posedge TCK) disable iff (!TRST_N) TMS [*5] |=> t.state == st_reset)
    else $error("five high mode selects did not reach reset");
  a_ir_load: assert property (
    @(posedge TCK) disable iff (!TRST_N) t.state == st_uir |=> t.ir == $past(t.shift[3:0]))
    else $error("instruction not loaded on update");
  a_tdo_oe: assert property (
    @(negedge TCK) disable iff (!TRST_N)
    TDO_OE |-> $past(t.state) inside {st_cdr, st_shdr, st_e2dr, st_cir, st_shir, st_e2ir})
    else $error("data out enabled outside shifting");
  a_returned_test_clock_follow: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    $changed(s.tck_s2) |=> RETURNED_TEST_CLOCK == $past(s.tck_s2))
    else $error("returned clock does not follow");
  a_halt_hit: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    !s.dctrl[`DC_CHAIN] && !s.dctrl[`DC_RANGE] && hit[0] |=> CORE_HALT)
    else $error("enabled match did not halt");
  a_chain_order: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    s.dctrl[`DC_CHAIN] && !s.dctrl[`DC_FORCE] && !s.halted && !s.armed
    |=> !CORE_HALT)
    else $error("chained halt without unit 0 first");
  a_range_out: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    s.dctrl[`DC_RANGE] && !s.dctrl[`DC_CHAIN] && !s.dctrl[`DC_FORCE]
    && !s.halted && hit[1] |=> !CORE_HALT)
    else $error("range halt inside excluded region");
  a_force_halt: assert property (
    @(posedge SYS_CLK) disable iff (RESET) s.dctrl[`DC_FORCE] |=> CORE_HALT [*2])
    else $error("forced debug state not held");
  a_cp_number: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    CP_ACK |-> $past(CP_REQ) && $past(CP_NUM) == `CP_DEBUG)
    else $error("channel answered a foreign coprocessor");
  a_tx_flag: assert property (
    @(posedge SYS_CLK) disable iff (RESET)
    CP_REQ && CP_NUM == `CP_DEBUG && CP_WRITE && CP_SEL |=> s.tx_full)
    else $error("write full flag not set");
  a_insert_halt: assert property (
    @(posedge SYS_CLK) disable iff (RESET) INSERT_VALID |-> $past(s.halted))
    else $error("insert outside debug state");
  c_chain_halt: cover property (
    @(posedge SYS_CLK) disable iff (RESET) s.dctrl[`DC_CHAIN] && $rose(CORE_HALT));
  c_range_halt: cover property (
    @(posedge SYS_CLK) disable iff (RESET) s.dctrl[`DC_RANGE] && $rose(CORE_HALT));
  c_channel: cover property (
    @(posedge SYS_CLK) disable iff (RESET) rx_set ##[1:50] rx_clr);
  c_insert: cover property (
    @(posedge SYS_CLK) disable iff (RESET) INSERT_VALID && INSERT_FAST);
endmodule
`default_nettype wire

// ### verification/jtag_debugger_model.sv
`timescale 1ns/1ps
`default_nettype none
module jtag_debugger_model (
  output var  logic TCK,
  output var  logic TMS,
  output var  logic TDI,
  input  wire logic TDO,
  input  wire logic RETURNED_TEST_CLOCK
);
  logic adaptive;
  int   late;
  // test clock stands low between frames
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
    adaptive = 1'b0;
    late = 0;
  end
  // ----------------------------------------
  // one test clock, optionally paced on the return
  // ----------------------------------------
  task automatic pace(input logic lvl);
    int i;
    for (i = 0; i < 40 && RETURNED_TEST_CLOCK !== lvl; i++) #10;
    if (RETURNED_TEST_CLOCK !== lvl) late++;
  endtask
  task automatic step(input logic m, input logic d, output logic q);
    TMS = m;
    TDI = d;
    #80 q = TDO;
    TCK = 1'b1;
    if (adaptive) pace(1'b1);
    #80 TCK = 1'b0;
    if (adaptive) pace(1'b0);
  endtask
  task automatic idle(input int n);
    logic q;
    repeat (n) step(1'b0, ~TDI, q);
  endtask
  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, ~TDI, q);
    step(1'b0, ~TDI, q);
  endtask
  // from idle: ir selects the instruction path; bits go lsb first
  task automatic scan(input logic ir, input int n, input logic [37:0] d,
                      output logic [37:0] q);
    logic x;
    int   i;
    q = '0;
    step(1'b1, ~TDI, x);
    if (ir) step(1'b1, ~TDI, x);
    step(1'b0, ~TDI, x);
    step(1'b0, ~TDI, x);
    for (i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
    step(1'b1, ~TDI, x);
    step(1'b0, ~TDI, x);
  endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`include "jtag_dbg_cfg.svh"
`default_nettype none
module tb;
  logic        sys_clk, reset, trst_n, core_access, core_fetch, cp_req, cp_write, cp_sel;
  logic [31:0] core_addr, core_data, cp_wdata, insert_data, cp_rdata;
  logic [6:0]  core_ctrl;
  logic [3:0]  cp_num;
  logic        tck, tms, tdi, tdo, returned_test_clock, core_halt, int_dis, insert_valid, insert_fast, cp_ack;
  logic        tdo_oe;
  int          n_fail, checked, n_ins, n_oe;
  logic [37:0] q;
  logic [31:0] d;

  jtag_watchpoint_debug_unit uut (.SYS_CLK(sys_clk), .RESET(reset), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TRST_N(trst_n), .TDO(tdo), .TDO_OE(tdo_oe), .RETURNED_TEST_CLOCK(returned_test_clock),
    .CORE_ACCESS(core_access), .CORE_FETCH(core_fetch), .CORE_ADDR(core_addr),
    .CORE_DATA(core_data), .CORE_CTRL(core_ctrl), .CORE_HALT(core_halt),
    .CORE_INT_DISABLE(int_dis), .INSERT_VALID(insert_valid), .INSERT_DATA(insert_data),
    .INSERT_FAST(insert_fast), .CP_REQ(cp_req), .CP_NUM(cp_num), .CP_WRITE(cp_write),
    .CP_SEL(cp_sel), .CP_WDATA(cp_wdata), .CP_ACK(cp_ack), .CP_RDATA(cp_rdata));
  // a released data out reads as its inverse, so a stale bit cannot pass
  jtag_debugger_model host (.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo_oe ? tdo : ~tdo),
    .RETURNED_TEST_CLOCK(returned_test_clock));

  always #50 sys_clk = ~sys_clk;
  // insert is a one-cycle pulse, so count it mid-cycle rather than poll for it
  always @(negedge sys_clk) if (insert_valid === 1'b1) n_ins++;
  always @(posedge tck) if (tdo_oe === 1'b1) n_oe++;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // idle long enough for the handshake across domains
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    host.scan(1'b0, 38, {1'b1, a, v}, q);
    host.idle(8);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    host.scan(1'b0, 38, {1'b0, a, 32'h0}, q);
    host.idle(8);
    host.scan(1'b0, 38, {1'b0, a, 32'h0}, q);
    host.idle(8);
    v = q[31:0];
  endtask
  task automatic sel(input logic [3:0] c);
    host.scan(1'b1, 4, {34'h0, `IR_SCAN_N}, q);
    host.scan(1'b0, 4, {34'h0, c}, q);
    host.scan(1'b1, 4, {34'h0, `IR_INTEST}, q);
  endtask
  task automatic unit(input logic [1:0] u, input logic [31:0] av, input logic [31:0] am,
                      input logic [8:0] cv, input logic [7:0] cm);
    wr({u, `WF_ADDR_VAL}, av);
    wr({u, `WF_ADDR_MASK}, am);
    wr({u, `WF_DATA_MASK}, 32'hffffffff);
    wr({u, `WF_CTRL_VAL}, {23'h0, cv});
    wr({u, `WF_CTRL_MASK}, {24'h0, cm});
  endtask
  task automatic acc(input logic [31:0] a, input logic f, input logic e);
    @(posedge sys_clk);
    core_access <= 1'b1;
    core_addr <= a;
    core_fetch <= f;
    @(posedge sys_clk);
    core_access <= 1'b0;
    #1 chk(core_halt, e);
  endtask
  task automatic cp(input logic w, input logic s, input logic [3:0] n,
                    input logic [31:0] v, input logic [31:0] e);
    @(posedge sys_clk);
    cp_req <= 1'b1;
    cp_write <= w;
    cp_sel <= s;
    cp_num <= n;
    cp_wdata <= v;
    @(posedge sys_clk);
    cp_req <= 1'b0;
    #1 chk(cp_ack, n == `CP_DEBUG);
    if (!w && n == `CP_DEBUG) chk(cp_rdata, e);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_tap();
    host.scan(1'b1, 4, {34'h0, `IR_BYPASS}, q);
    chk(q[3:0], `IR_CAPTURE);
    host.scan(1'b0, 8, 38'ha5, q);
    chk(q[7:0], 8'h4a);
    chk(n_oe, 12);
    $display("tap test done");
  endtask
  task automatic t_regs();
    sel(`CHAIN_DEBUG);
    wr({`RA_UNIT1, `WF_ADDR_VAL}, 32'h12345678);
    rd({`RA_UNIT1, `WF_ADDR_VAL}, d);
    chk(d, 32'h12345678);
    wr(`RA_DBG_CTRL, 32'h2);
    chk(int_dis, 1'b1);
    rd(`RA_DBG_CTRL, d);
    chk(d, 32'h2);
    rd(5'h1f, d);
    chk(d, 32'h0);
    wr(`RA_DBG_CTRL, 32'h0);
    $display("register test done");
  endtask
  task automatic t_watch();
    unit(`RA_UNIT0, 32'h100, 32'h0, 9'h100, 8'hfe);
    acc(32'h104, 1'b0, 1'b0);
    acc(32'h100, 1'b0, 1'b1);
    wr(`RA_DBG_CTRL, 32'h20);
    wr({`RA_UNIT0, `WF_ADDR_MASK}, 32'hff);
    @(posedge sys_clk);
    core_ctrl <= 7'h55;
    acc(32'h1ab, 1'b0, 1'b1);
    wr(`RA_DBG_CTRL, 32'h20);
    wr({`RA_UNIT0, `WF_CTRL_VAL}, 32'h101);
    acc(32'h100, 1'b0, 1'b0);
    acc(32'h100, 1'b1, 1'b1);
    wr(`RA_DBG_CTRL, 32'h20);
    $display("watch test done");
  endtask
  task automatic t_modes();
    unit(`RA_UNIT0, 32'h0, 32'hff, 9'h100, 8'hff);
    unit(`RA_UNIT1, 32'h0, 32'h1f, 9'h100, 8'hff);
    wr(`RA_DBG_CTRL, 32'h08);
    acc(32'h10, 1'b0, 1'b0);
    acc(32'h100, 1'b0, 1'b0);
    acc(32'h40, 1'b0, 1'b1);
    wr(`RA_DBG_CTRL, 32'h24);
    unit(`RA_UNIT0, 32'h200, 32'h0, 9'h100, 8'hff);
    unit(`RA_UNIT1, 32'h300, 32'h0, 9'h100, 8'hff);
    acc(32'h300, 1'b0, 1'b0);
    acc(32'h200, 1'b0, 1'b0);
    acc(32'h300, 1'b0, 1'b1);
    wr(`RA_DBG_CTRL, 32'h20);
    wr({`RA_UNIT0, `WF_CTRL_VAL}, 32'h0);
    wr({`RA_UNIT1, `WF_CTRL_VAL}, 32'h0);
    $display("mode test done");
  endtask
  task automatic t_comm();
    cp(1'b1, 1'b1, 4'hd, 32'hdeadbeef, 32'h0);
    cp(1'b1, 1'b1, `CP_DEBUG, 32'hcafe0001, 32'h0);
    rd(`RA_COMM_CTRL, d);
    chk(d, 32'h2);
    rd(`RA_COMM_DATA, d);
    chk(d, 32'hcafe0001);
    rd(`RA_COMM_CTRL, d);
    chk(d, 32'h0);
    wr(`RA_COMM_DATA, 32'h5a5a5a5a);
    cp(1'b0, 1'b0, `CP_DEBUG, 32'h0, 32'h1);
    cp(1'b0, 1'b1, `CP_DEBUG, 32'h0, 32'h5a5a5a5a);
    cp(1'b0, 1'b0, `CP_DEBUG, 32'h0, 32'h0);
    chk(core_halt, 1'b0);
    $display("channel test done");
  endtask
  task automatic t_insert();
    wr(`RA_DBG_CTRL, 32'h1);
    chk(core_halt, 1'b1);
    sel(`CHAIN_CORE);
    @(posedge sys_clk);
    core_data <= 32'h0f1e2d3c;
    host.scan(1'b0, 33, {5'h0, 1'b1, 32'h89abcdef}, q);
    host.idle(8);
    chk(n_ins, 1);
    chk({insert_fast, insert_data}, {1'b1, 32'h89abcdef});
    host.scan(1'b0, 33, {5'h0, 1'b0, 32'h2468ace0}, q);
    host.idle(8);
    chk(q[31:0], 32'h0f1e2d3c);
    chk({insert_fast, insert_data}, {1'b0, 32'h2468ace0});
    sel(`CHAIN_DEBUG);
    // force must drop before the release, since a set in the same cycle wins
    wr(`RA_DBG_CTRL, 32'h0);
    wr(`RA_DBG_CTRL, 32'h20);
    chk(core_halt, 1'b0);
    $display("insert test done");
  endtask
  task automatic t_trst();
    host.adaptive = 1'b1;
    wr(`RA_DBG_CTRL, 32'h2);
    @(posedge sys_clk);
    trst_n <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    trst_n <= 1'b1;
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(int_dis, 1'b0);
    host.idle(1);
    host.scan(1'b0, 8, 38'h3c, q);
    chk(q[7:0], 8'h78);
    chk(host.late, 0);
    $display("test reset done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0; reset = 1'b1; trst_n = 1'b0; core_access = 1'b0; core_fetch = 1'b0;
    core_addr = 32'h0; core_data = 32'h13579bdf; core_ctrl = 7'h0; cp_req = 1'b0;
    cp_write = 1'b0; cp_sel = 1'b0; cp_num = 4'h0; cp_wdata = 32'h0;
    n_fail = 0; checked = 0; n_ins = 0; n_oe = 0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    trst_n <= 1'b1;
    @(posedge sys_clk);
    host.reset_tap();
    t_tap();
    t_regs();
    t_watch();
    t_modes();
    t_comm();
    t_insert();
    t_trst();
    finish_test();
  end
  // a hang anywhere ends in the same report
  initial begin
    #5ms;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
